// ==== atc_pkg.sv ====
// Shared constants for the advanced timer core
package atc_pkg;
	localparam logic [7:0] ADDR_PERIOD = 8'h00;
	localparam logic [7:0] ADDR_COUNT = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_CMP = 8'h0C;
	localparam logic [7:0] ADDR_FLAGS = 8'h10;
	localparam logic [7:0] ADDR_FCLR = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;

	localparam int CTRL_EN = 0;
	localparam int CTRL_COMP = 1;
	localparam int CTRL_SRC = 2;
	localparam int CTRL_SPC = 3;
	localparam int CTRL_PRS_LO = 4;
	localparam int CTRL_BUF = 7;
	localparam int CTRL_SINGLE = 14;
	localparam int CTRL_SWUPD = 25;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0008;

	localparam int FLAG_W = 19;
	localparam int FLG_UPD = 0;
	localparam int FLG_MATCH_LO = 2;
	localparam int FLG_LOSS_LO = 8;
	localparam int FLG_BRAKE = 14;
	localparam int FLG_TRIG = 15;
	localparam int FLG_OVF = 16;
	localparam int FLG_UNDERFLOW_FLAG = 17;
	localparam int FLG_CH4 = 18;
	localparam logic [FLAG_W-1:0] FLAG_IMPL = 19'h7FFFD;
	localparam logic [FLAG_W-1:0] FLAG_RESET = 19'h00000;
	localparam logic [31:0] FCLR_READ = 32'h0007_FFFF;

	localparam logic [15:0] PERIOD_RESET = 16'h0000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] CMP_RESET = 16'h0000;
	localparam logic [7:0] PRS_COUNT_RESET = 8'h00;

	// Terminal count of the prescaler: divisor minus one
	function automatic logic [7:0] prs_last(input logic [2:0] sel);
		logic [7:0] v;
		v = 8'h00;
		unique case (sel)
			3'h0: v = 8'h00;
			3'h1: v = 8'h01;
			3'h2: v = 8'h03;
			3'h3: v = 8'h07;
			3'h4: v = 8'h0F;
			3'h5: v = 8'h1F;
			3'h6: v = 8'h3F;
			3'h7: v = 8'hFF;
		endcase
		return v;
	endfunction
endpackage

// ==== atc_reg_if.sv ====
// Register access carrier between bus slave and timer core
`timescale 1ns/1ps
interface atc_reg_if;
	logic wr;
	logic rd;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	modport bus (output wr, output rd, output addr, output wdata, input rdata);
	modport regs (input wr, input rd, input addr, input wdata, output rdata);
endinterface

// ==== atc_ahb_slave.sv ====
// AHB-Lite slave front end: zero-wait writes, one wait state on reads
`timescale 1ns/1ps
module atc_ahb_slave (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	atc_reg_if.bus reg_bus
);
	logic accept;
	logic wr_pend_q;
	logic rd_pend_q;
	logic [7:0] addr_q;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic hresp_q;

	assign accept = hsel & hready & htrans[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= 8'h00;
		end else if (hready) begin
			wr_pend_q <= accept & hwrite;
			rd_pend_q <= accept & ~hwrite;
			addr_q <= haddr[7:0];
		end else begin
			rd_pend_q <= 1'b0;
		end
	end

	// Read data sampled a cycle late so a preceding write is always visible
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
			hreadyout_q <= 1'b1;
		end else begin
			hreadyout_q <= ~(accept & ~hwrite);
			if (rd_pend_q) begin
				hrdata_q <= reg_bus.rdata;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp_q <= 1'b0;
		end else begin
			hresp_q <= 1'b0;
		end
	end

	assign reg_bus.wr = wr_pend_q;
	assign reg_bus.rd = rd_pend_q;
	assign reg_bus.addr = addr_q;
	assign reg_bus.wdata = hwdata;
	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
endmodule

// ==== atc_prescaler.sv ====
// Bus clock prescaler producing one-cycle count ticks
`timescale 1ns/1ps
module atc_prescaler #(
	parameter int CW = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clear,
	input wire logic run,
	input wire logic [2:0] sel,
	output logic tick
);
	logic [CW-1:0] count_q;
	logic tick_q;
	logic [CW-1:0] last;

	assign last = CW'(atc_pkg::prs_last(sel));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_q <= CW'(atc_pkg::PRS_COUNT_RESET);
			tick_q <= 1'b0;
		end else if (clear || !run) begin
			count_q <= CW'(atc_pkg::PRS_COUNT_RESET);
			tick_q <= 1'b0;
		end else if (count_q == last) begin
			count_q <= CW'(atc_pkg::PRS_COUNT_RESET);
			tick_q <= 1'b1;
		end else begin
			count_q <= count_q + CW'(1);
			tick_q <= 1'b0;
		end
	end

	assign tick = tick_q;
endmodule

// ==== atc_timer_core.sv ====
// Advanced timer core: control, period, counter, flags and compare references
//
// How it works
// - Buffer bit picks immediate or update-time period load
// - Prescaler codes divide by 1..64, code 7 by 256
// - Compare mode resets 1; selects one- or two-point A
// - Reference B follows channel B compare only
// - Count source: bus clock or external trigger edges
// - Output mode: independent or complementary pair
// - Enable runs counter; trigger sets; single-cycle end clears
// - Period write immediate when disabled or unbuffered
// - Counter at 0x04, live, read and write
// - Update flag set on update event, sticky
// - Bits 2..7 record channel match events
// - Bits 8..13 record channel capture loss
// - Bits 14..18 brake, trigger, overflow, underflow, ch4
// - Clear register: write zero clears, reads ones
// - Single-cycle mode stops counting at the period wrap, not on a software update
// - Software update restarts counter, prescaler, loads buffers
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
module atc_timer_core (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic external_trigger_input,
	input wire logic [5:0] ch_match_evt,
	input wire logic [5:0] ch_loss_evt,
	input wire logic brake_evt,
	input wire logic trigger_evt,
	input wire logic underflow_evt,
	input wire logic ch4_match_evt,
	output logic compare_reference_a,
	output logic compare_reference_b,
	output logic pwm_out_a,
	output logic pwm_out_b,
	output logic irq
);
	atc_reg_if reg_bus ();

	// Control fields
	logic timer_enable_q;
	logic output_mode_q;
	logic count_clock_source_q;
	logic single_point_compare_select_q;
	logic [2:0] clock_divider_select_q;
	logic period_buffer_enable_q;
	logic single_cycle_mode_q;

	logic [15:0] period_value_q;
	logic [15:0] period_active_q;
	logic [15:0] counter_value_q;
	logic [15:0] cmp_a_q;
	logic [15:0] cmp_b_q;
	logic [15:0] cmp_a_act_q;
	logic [15:0] cmp_b_act_q;
	logic [atc_pkg::FLAG_W-1:0] event_flags_q;
	logic [atc_pkg::FLAG_W-1:0] irq_status_q;
	logic [atc_pkg::FLAG_W-1:0] irq_mask_q;

	logic ext_s1_q;
	logic ext_s2_q;
	logic ext_s3_q;
	logic ref_a_q;
	logic ref_b_q;
	logic pwm_a_q;
	logic pwm_b_q;
	logic irq_q;

	logic presc_tick;
	logic ext_rise;
	logic count_tick;
	logic at_period;
	logic wrap_evt;
	logic sw_update;
	logic update_evt;
	logic load_now;
	logic wr_ctrl;
	logic wr_period;
	logic wr_count;
	logic wr_cmp;
	logic wr_fclr;
	logic wr_mask;
	logic rd_irq_stat;
	logic ref_a_d;
	logic ref_b_d;
	logic [atc_pkg::FLAG_W-1:0] flag_set;
	logic [atc_pkg::FLAG_W-1:0] flag_clr;
	logic [31:0] ctrl_rd;

	atc_ahb_slave u_bus (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hready(hready),
		.hwdata(hwdata),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.reg_bus(reg_bus)
	);

	// Write decode; only whole-word transfers are supported, hsize unused
	assign wr_ctrl = reg_bus.wr && (reg_bus.addr == atc_pkg::ADDR_CTRL);
	assign wr_period = reg_bus.wr && (reg_bus.addr == atc_pkg::ADDR_PERIOD);
	assign wr_count = reg_bus.wr && (reg_bus.addr == atc_pkg::ADDR_COUNT);
	assign wr_cmp = reg_bus.wr && (reg_bus.addr == atc_pkg::ADDR_CMP);
	assign wr_fclr = reg_bus.wr && (reg_bus.addr == atc_pkg::ADDR_FCLR);
	assign wr_mask = reg_bus.wr && (reg_bus.addr == atc_pkg::ADDR_IRQ_MASK);
	assign rd_irq_stat = reg_bus.rd && (reg_bus.addr == atc_pkg::ADDR_IRQ_STAT);

	assign sw_update = wr_ctrl && reg_bus.wdata[atc_pkg::CTRL_SWUPD];

	atc_prescaler #(
		.CW(8)
	) u_presc (
		.hclk(hclk),
		.hresetn(hresetn),
		.clear(sw_update),
		.run(timer_enable_q && !count_clock_source_q),
		.sel(clock_divider_select_q),
		.tick(presc_tick)
	);

	// External trigger pin resynchronised before edge detection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end else begin
			ext_s1_q <= external_trigger_input;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	assign ext_rise = ext_s2_q && !ext_s3_q;
	assign count_tick = timer_enable_q && (count_clock_source_q ? ext_rise : presc_tick);
	assign at_period = (counter_value_q == period_active_q);
	assign wrap_evt = count_tick && at_period && !wr_count;
	assign update_evt = wrap_evt || sw_update;
	assign load_now = !period_buffer_enable_q || !timer_enable_q;

	// Control register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			output_mode_q <= atc_pkg::CTRL_RESET[atc_pkg::CTRL_COMP];
			count_clock_source_q <= atc_pkg::CTRL_RESET[atc_pkg::CTRL_SRC];
			single_point_compare_select_q <= atc_pkg::CTRL_RESET[atc_pkg::CTRL_SPC];
			clock_divider_select_q <= atc_pkg::CTRL_RESET[atc_pkg::CTRL_PRS_LO +: 3];
			period_buffer_enable_q <= atc_pkg::CTRL_RESET[atc_pkg::CTRL_BUF];
			single_cycle_mode_q <= atc_pkg::CTRL_RESET[atc_pkg::CTRL_SINGLE];
		end else if (wr_ctrl) begin
			output_mode_q <= reg_bus.wdata[atc_pkg::CTRL_COMP];
			count_clock_source_q <= reg_bus.wdata[atc_pkg::CTRL_SRC];
			single_point_compare_select_q <= reg_bus.wdata[atc_pkg::CTRL_SPC];
			clock_divider_select_q <= reg_bus.wdata[atc_pkg::CTRL_PRS_LO +: 3];
			period_buffer_enable_q <= reg_bus.wdata[atc_pkg::CTRL_BUF];
			single_cycle_mode_q <= reg_bus.wdata[atc_pkg::CTRL_SINGLE];
		end
	end

	// Enable: a completed single cycle beats both software and trigger
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_enable_q <= atc_pkg::CTRL_RESET[atc_pkg::CTRL_EN];
		end else if (wrap_evt && single_cycle_mode_q) begin
			timer_enable_q <= 1'b0;
		end else if (trigger_evt) begin
			timer_enable_q <= 1'b1;
		end else if (wr_ctrl) begin
			timer_enable_q <= reg_bus.wdata[atc_pkg::CTRL_EN];
		end
	end

	// Period preload and active copy
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			period_value_q <= atc_pkg::PERIOD_RESET;
			period_active_q <= atc_pkg::PERIOD_RESET;
		end else if (wr_period) begin
			period_value_q <= reg_bus.wdata[15:0];
			if (load_now) begin
				period_active_q <= reg_bus.wdata[15:0];
			end
		end else if (update_evt) begin
			period_active_q <= period_value_q;
		end
	end

	// Compare values follow the same buffering as the period
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmp_a_q <= atc_pkg::CMP_RESET;
			cmp_b_q <= atc_pkg::CMP_RESET;
			cmp_a_act_q <= atc_pkg::CMP_RESET;
			cmp_b_act_q <= atc_pkg::CMP_RESET;
		end else if (wr_cmp) begin
			cmp_a_q <= reg_bus.wdata[15:0];
			cmp_b_q <= reg_bus.wdata[31:16];
			if (load_now) begin
				cmp_a_act_q <= reg_bus.wdata[15:0];
				cmp_b_act_q <= reg_bus.wdata[31:16];
			end
		end else if (update_evt) begin
			cmp_a_act_q <= cmp_a_q;
			cmp_b_act_q <= cmp_b_q;
		end
	end

	// Counter; a software write wins over a tick in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			counter_value_q <= atc_pkg::COUNT_RESET;
		end else if (wr_count) begin
			counter_value_q <= reg_bus.wdata[15:0];
		end else if (sw_update) begin
			counter_value_q <= atc_pkg::COUNT_RESET;
		end else if (count_tick) begin
			counter_value_q <= at_period ? atc_pkg::COUNT_RESET : counter_value_q + 16'h0001;
		end
	end

	// Event sources into the common flag layout
	always_comb begin
		flag_set = '0;
		flag_set[atc_pkg::FLG_UPD] = update_evt;
		flag_set[atc_pkg::FLG_MATCH_LO +: 6] = ch_match_evt;
		flag_set[atc_pkg::FLG_LOSS_LO +: 6] = ch_loss_evt;
		flag_set[atc_pkg::FLG_BRAKE] = brake_evt;
		flag_set[atc_pkg::FLG_TRIG] = trigger_evt;
		flag_set[atc_pkg::FLG_OVF] = wrap_evt;
		flag_set[atc_pkg::FLG_UNDERFLOW_FLAG] = underflow_evt;
		flag_set[atc_pkg::FLG_CH4] = ch4_match_evt;
	end

	assign flag_clr = wr_fclr ? (~reg_bus.wdata[atc_pkg::FLAG_W-1:0] & atc_pkg::FLAG_IMPL) : '0;

	// Sticky flags; a new event beats a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			event_flags_q <= atc_pkg::FLAG_RESET;
		end else begin
			event_flags_q <= ((event_flags_q & ~flag_clr) | flag_set) & atc_pkg::FLAG_IMPL;
		end
	end

	// Interrupt status cleared by reading it; set wins here too
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status_q <= atc_pkg::FLAG_RESET;
			irq_mask_q <= atc_pkg::FLAG_RESET;
		end else begin
			irq_status_q <= ((rd_irq_stat ? '0 : irq_status_q) | flag_set) & atc_pkg::FLAG_IMPL;
			if (wr_mask) begin
				irq_mask_q <= reg_bus.wdata[atc_pkg::FLAG_W-1:0] & atc_pkg::FLAG_IMPL;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_status_q & irq_mask_q);
		end
	end

	// Compare references; the counter must start below the period
	always_comb begin
		ref_b_d = counter_value_q < cmp_b_act_q;
		if (single_point_compare_select_q) begin
			ref_a_d = counter_value_q < cmp_a_act_q;
		end else begin
			ref_a_d = (counter_value_q >= cmp_a_act_q) && (counter_value_q < cmp_b_act_q);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ref_a_q <= 1'b0;
			ref_b_q <= 1'b0;
			pwm_a_q <= 1'b0;
			pwm_b_q <= 1'b0;
		end else begin
			ref_a_q <= ref_a_d;
			ref_b_q <= ref_b_d;
			pwm_a_q <= ref_a_d;
			pwm_b_q <= output_mode_q ? ~ref_a_d : ref_b_d;
		end
	end

	// Control read-back; update request always reads zero
	always_comb begin
		ctrl_rd = 32'h0000_0000;
		ctrl_rd[atc_pkg::CTRL_EN] = timer_enable_q;
		ctrl_rd[atc_pkg::CTRL_COMP] = output_mode_q;
		ctrl_rd[atc_pkg::CTRL_SRC] = count_clock_source_q;
		ctrl_rd[atc_pkg::CTRL_SPC] = single_point_compare_select_q;
		ctrl_rd[atc_pkg::CTRL_PRS_LO +: 3] = clock_divider_select_q;
		ctrl_rd[atc_pkg::CTRL_BUF] = period_buffer_enable_q;
		ctrl_rd[atc_pkg::CTRL_SINGLE] = single_cycle_mode_q;
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		unique case (reg_bus.addr)
			atc_pkg::ADDR_PERIOD: reg_bus.rdata = {16'h0000, period_value_q};
			atc_pkg::ADDR_COUNT: reg_bus.rdata = {16'h0000, counter_value_q};
			atc_pkg::ADDR_CTRL: reg_bus.rdata = ctrl_rd;
			atc_pkg::ADDR_CMP: reg_bus.rdata = {cmp_b_q, cmp_a_q};
			atc_pkg::ADDR_FLAGS: reg_bus.rdata = {13'h0000, event_flags_q};
			atc_pkg::ADDR_FCLR: reg_bus.rdata = atc_pkg::FCLR_READ;
			atc_pkg::ADDR_IRQ_STAT: reg_bus.rdata = {13'h0000, irq_status_q};
			atc_pkg::ADDR_IRQ_MASK: reg_bus.rdata = {13'h0000, irq_mask_q};
			default: reg_bus.rdata = 32'h0000_0000;
		endcase
	end

	assign compare_reference_a = ref_a_q;
	assign compare_reference_b = ref_b_q;
	assign pwm_out_a = pwm_a_q;
	assign pwm_out_b = pwm_b_q;
	assign irq = irq_q;
endmodule

// ==== atc_timer_core_chk.sv ====
// Bus timing and readback checks for the timer core
`timescale 1ns/1ps
module atc_timer_core_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp
);
	logic rd;
	assign rd = hsel && hready && htrans[1] && !hwrite;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_OKAY: assert property (hresp == 1'b0)
		else $error("hresp not okay");
	AST_RD_WAIT: assert property (rd |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	AST_WR_NOWAIT: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
		else $error("write inserted a wait");
	AST_RD_HOLD: assert property ($changed(hrdata) |-> $rose(hreadyout))
		else $error("read data moved outside a read");
	AST_FCLR: assert property (rd && haddr[7:0] == 8'h14 |=> ##1 hrdata == 32'h0007FFFF)
		else $error("flag clear readback wrong");
	AST_FLG_RSV: assert property (rd && haddr[7:0] == 8'h10 |=> ##1 hrdata[31:19] == 13'h0000 && !hrdata[1])
		else $error("flag reserved bits set");
	AST_CNT_RSV: assert property (rd && haddr[7:3] == 5'h00 |=> ##1 hrdata[31:16] == 16'h0000)
		else $error("upper half not zero");
	AST_UNMAP: assert property (rd && haddr[7:0] == 8'h30 |=> ##1 hrdata == 32'h00000000)
		else $error("unmapped read not zero");
endmodule
bind atc_timer_core atc_timer_core_chk chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

// ==== tb_atc_timer_core.sv ====
// Self-checking bench for the timer core
`timescale 1ns/1ps
module tb_atc_timer_core;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata;
	logic hreadyout, hresp, ref_a, ref_b, pwm_a, pwm_b, irq, ra, rb, pb;
	logic pend = 1'b0;
	logic ext = 1'b0;
	logic [18:0] ev = 19'h00000;
	logic [1:0] m;
	logic [31:0] eq[$];
	logic [31:0] mq[$];
	int err_count = 0;
	int n_tests = 0;
	int n, c, rs;
	always #5 hclk = ~hclk;
	atc_timer_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .external_trigger_input(ext), .ch_match_evt(ev[7:2]),
		.ch_loss_evt(ev[13:8]), .brake_evt(ev[14]), .trigger_evt(ev[15]), .underflow_evt(ev[17]),
		.ch4_match_evt(ev[18]), .compare_reference_a(ref_a), .compare_reference_b(ref_b),
		.pwm_out_a(pwm_a), .pwm_out_b(pwm_b), .irq(irq));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge hclk);
	endtask
	// Read notes its expectation; the monitor compares when data arrives
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] k);
		if (!w) begin
			eq.push_back(d);
			mq.push_back(k);
		end
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= w ? d : 32'h00000000;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
	endtask
	task automatic pl(input logic [18:0] v);
		ev <= v;
		@(posedge hclk);
		ev <= 19'h00000;
	endtask
	task automatic note(input string s);
		$display("test finished: %s", s);
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge hclk) begin
		logic [31:0] k;
		if (pend === 1'b1 && hreadyout === 1'b1) begin
			k = mq.pop_front();
			chk(hrdata & k, eq.pop_front() & k);
		end
		if (hsel && hreadyout && htrans[1] && !hwrite)
			pend <= 1'b1;
		else if (hreadyout)
			pend <= 1'b0;
	end
	initial begin
		#500000;
		err_count++;
		conclude();
	end
	initial begin
		rs = $urandom(32'h8021);
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(0, 8'h00, 0, '1);
		bus(0, 8'h04, 0, '1);
		bus(0, 8'h08, 32'h8, '1);
		bus(0, 8'h10, 0, '1);
		bus(0, 8'h14, 32'h7FFFF, '1);
		bus(1, 8'h30, '1, 0);
		bus(0, 8'h30, 0, '1);
		bus(1, 8'h04, 32'h0000_1234, 0);
		bus(0, 8'h04, 32'h1234, '1);
		note("reset and readback");
		for (int k = 2; k < 19; k++) begin
			if (k == 16)
				continue;
			pl(19'h1 << k);
			bus(0, 8'h10, 32'h1 << k, 32'h1 << k);
			bus(1, 8'h14, ~(32'h1 << k) & 32'h0007_FFFF, 0);
			bus(0, 8'h10, 0, 32'h1 << k);
		end
		bus(0, 8'h08, 1, 1);
		note("event flags");
		bus(1, 8'h00, 32'hFFFF, 0);
		// Window of N/2 absorbs the tick start offset
		for (int s = 0; s < 8; s++) begin
			n = (s == 7) ? 256 : (1 << s);
			bus(1, 8'h08, 32'h02000009 | (s << 4), 0);
			cyc(20 * n + n / 2);
			bus(0, 8'h04, 20, 32'hFFF8);
		end
		note("prescaler");
		bus(1, 8'h08, 32'h8, 0);
		bus(1, 8'h14, 0, 0);
		bus(1, 8'h00, 3, 0);
		bus(1, 8'h04, 0, 0);
		bus(1, 8'h08, 32'h4009, 0);
		cyc(20);
		bus(0, 8'h08, 32'h4008, '1);
		bus(0, 8'h04, 0, '1);
		bus(0, 8'h10, 32'h10001, 32'h10001);
		note("single cycle");
		bus(1, 8'h08, 32'h88, 0);
		bus(1, 8'h00, 200, 0);
		bus(1, 8'h08, 32'h89, 0);
		bus(1, 8'h00, 3, 0);
		bus(1, 8'h04, 0, 0);
		cyc(22);
		bus(0, 8'h04, 16, 32'hFFF0);
		bus(1, 8'h08, 32'h09, 0);
		bus(1, 8'h00, 3, 0);
		bus(1, 8'h04, 0, 0);
		cyc(22);
		bus(0, 8'h04, 0, 32'hFFFC);
		note("period buffer");
		bus(1, 8'h0C, 32'h0014000A, 0);
		bus(0, 8'h0C, 32'h0014_000A, '1);
		// Period above every random start so the counter begins below it
		bus(1, 8'h00, 32'h0000_001F, 0);
		repeat (12) begin
			c = $urandom % 30;
			m = 2'($urandom);
			bus(1, 8'h08, {28'h0, m[1], 1'b0, m[0], 1'b0}, 0);
			bus(1, 8'h04, 32'(c), 0);
			cyc(3);
			rb = c < 20;
			ra = m[1] ? c < 10 : (c >= 10 && c < 20);
			pb = m[0] ? ~ra : rb;
			chk({28'h0, pwm_a, ref_a, ref_b, pwm_b}, {28'h0, ra, ra, rb, pb});
		end
		note("compare references");
		bus(1, 8'h00, 32'hFFFF, 0);
		bus(1, 8'h08, 32'h0200000D, 0);
		repeat (5) begin
			ext <= 1'b1;
			cyc(4);
			ext <= 1'b0;
			cyc(4);
		end
		bus(0, 8'h04, 5, '1);
		note("external source");
		bus(1, 8'h08, 32'h8, 0);
		bus(1, 8'h24, 0, 0);
		bus(0, 8'h20, 0, 0);
		pl(19'h04000);
		cyc(3);
		chk(32'(irq), 0);
		bus(1, 8'h24, 32'h4000, 0);
		cyc(2);
		chk(32'(irq), 1);
		bus(0, 8'h24, 32'h0000_4000, '1);
		bus(0, 8'h20, 32'h4000, '1);
		cyc(2);
		chk(32'(irq), 0);
		note("interrupt");
		conclude();
	end
endmodule
